// File: hw/lke_io_trap.sv
// Decoder for trapped legacy I/O cycles and their read data.
`timescale 1ns/100ps
module lke_io_trap (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [7:0]  i_io_addr,
  input  wire logic        i_io_rd,
  input  wire logic        i_io_wr,
  input  wire logic [7:0]  i_io_wdata,
  output logic      [7:0]  o_io_rdata,
  output logic             o_io_rvalid,
  output logic             o_io_trapped,
  lke_trap_if.trap         trap
);

  typedef struct packed {
    logic [7:0] rdata;
    logic       rvalid;
  } lke_trap_state_t;

  lke_trap_state_t state_reg;
  lke_trap_state_t state_next;
  logic            hit_data;
  logic            hit_cmd;

  // Cycles are claimed only while emulation is on.
  assign hit_data = trap.emulation_enable
                    && (i_io_addr == lke_pkg::LKE_IO_DATA_PORT);
  assign hit_cmd  = trap.emulation_enable
                    && (i_io_addr == lke_pkg::LKE_IO_CMD_PORT);

  assign trap.rd_data_port = hit_data && i_io_rd;
  assign trap.wr_data_port = hit_data && i_io_wr && !i_io_rd;
  assign trap.rd_cmd_port  = hit_cmd && i_io_rd;
  assign trap.wr_cmd_port  = hit_cmd && i_io_wr && !i_io_rd;
  assign trap.wr_byte      = i_io_wdata;
  assign o_io_trapped      = (hit_data || hit_cmd) && (i_io_rd || i_io_wr);

  always_comb begin
    state_next        = state_reg;
    state_next.rvalid = 1'b0;
    if (trap.rd_data_port) begin
      state_next.rdata  = trap.out_data;
      state_next.rvalid = 1'b1;
    end else if (trap.rd_cmd_port) begin
      state_next.rdata  = trap.status;
      state_next.rvalid = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_io_rdata  = state_reg.rdata;
  assign o_io_rvalid = state_reg.rvalid;

endmodule : lke_io_trap

// File: hw/lke_pkg.sv
// Constants for the legacy keyboard emulation register set.
package lke_pkg;

  // Register offsets within the operational register space.
  localparam logic [11:0] LKE_OFS_CONTROL = 12'h100;
  localparam logic [11:0] LKE_OFS_INPUT   = 12'h104;
  localparam logic [11:0] LKE_OFS_OUTPUT  = 12'h108;
  localparam logic [11:0] LKE_OFS_STATUS  = 12'h10C;
  localparam int          LKE_ADDR_W      = 12;

  // Trapped legacy I/O ports.
  localparam logic [7:0] LKE_IO_DATA_PORT = 8'h60;
  localparam logic [7:0] LKE_IO_CMD_PORT  = 8'h64;

  // Control register fields.
  localparam int LKE_CTL_W      = 9;
  localparam int LKE_CTL_EMULATION_ENABLE = 0;
  localparam int LKE_CTL_EI     = 1;
  localparam int LKE_CTL_CP     = 2;
  localparam int LKE_CTL_IRQEN  = 3;
  localparam int LKE_CTL_EIRQEN = 4;
  localparam int LKE_CTL_GA20S  = 5;
  localparam int LKE_CTL_IRQ1A  = 6;
  localparam int LKE_CTL_IRQ12A = 7;
  localparam int LKE_CTL_A20S   = 8;
  localparam logic [8:0] LKE_CTL_RST     = 9'h000;
  localparam logic [8:0] LKE_CTL_WR_MASK = 9'h1FD;

  // Status register fields.
  localparam int LKE_STS_OUT_FULL = 0;
  localparam int LKE_STS_IN_FULL  = 1;
  localparam int LKE_STS_FLAG     = 2;
  localparam int LKE_STS_CMD_DATA = 3;
  localparam int LKE_STS_INH_SW   = 4;
  localparam int LKE_STS_AUX_FULL = 5;
  localparam int LKE_STS_TIMEOUT  = 6;
  localparam int LKE_STS_PARITY   = 7;
  localparam logic [7:0] LKE_STS_RST  = 8'h00;
  localparam logic [7:0] LKE_DATA_RST = 8'h00;

endpackage : lke_pkg

// File: hw/lke_top.sv
// Legacy keyboard emulation registers with I/O port trapping.
`timescale 1ns/100ps
module lke_top (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_mem_sel,
  input  wire logic        i_mem_wr,
  input  wire logic [11:0] i_mem_addr,
  input  wire logic [3:0]  i_mem_be,
  input  wire logic [31:0] i_mem_wdata,
  output logic      [31:0] o_mem_rdata,
  output logic             o_mem_rvalid,
  output logic             o_mem_hit,
  input  wire logic [7:0]  i_io_addr,
  input  wire logic        i_io_rd,
  input  wire logic        i_io_wr,
  input  wire logic [7:0]  i_io_wdata,
  output logic      [7:0]  o_io_rdata,
  output logic             o_io_rvalid,
  output logic             o_io_trapped,
  output logic             o_emul_irq,
  output logic             o_irq1,
  output logic             o_irq12,
  output logic             o_gate_a20
);

  typedef struct packed {
    logic [8:0]  ctl;
    logic [7:0]  in_data;
    logic [7:0]  out_data;
    logic [7:0]  sts;
    logic [31:0] rdata;
    logic        rvalid;
    logic        irq;
    logic        irq1;
    logic        irq12;
  } lke_state_t;

  lke_state_t state_reg;
  lke_state_t state_next;
  lke_trap_if trap ();

  logic        sel_ctl;
  logic        sel_in;
  logic        sel_out;
  logic        sel_sts;
  logic        mem_wr;
  logic        mem_rd;
  logic [8:0]  ctl_wmask;
  logic [8:0]  ctl_wval;
  logic        emulation_enable;
  logic        emul_cond;
  logic [31:0] rd_mux;

  lke_io_trap u_io_trap (
    .i_clk        (i_clk),
    .i_sys_rst    (i_sys_rst),
    .i_io_addr    (i_io_addr),
    .i_io_rd      (i_io_rd),
    .i_io_wr      (i_io_wr),
    .i_io_wdata   (i_io_wdata),
    .o_io_rdata   (o_io_rdata),
    .o_io_rvalid  (o_io_rvalid),
    .o_io_trapped (o_io_trapped),
    .trap         (trap.trap)
  );

  assign emulation_enable = state_reg.ctl[lke_pkg::LKE_CTL_EMULATION_ENABLE];
  assign trap.emulation_enable = emulation_enable;
  assign trap.out_data  = state_reg.out_data;
  assign trap.status    = state_reg.sts;

  // Word decode of the operational register space.
  assign sel_ctl = (i_mem_addr == lke_pkg::LKE_OFS_CONTROL);
  assign sel_in  = (i_mem_addr == lke_pkg::LKE_OFS_INPUT);
  assign sel_out = (i_mem_addr == lke_pkg::LKE_OFS_OUTPUT);
  assign sel_sts = (i_mem_addr == lke_pkg::LKE_OFS_STATUS);
  assign o_mem_hit = i_mem_sel && (sel_ctl || sel_in || sel_out || sel_sts);
  assign mem_wr  = i_mem_sel && i_mem_wr;
  assign mem_rd  = i_mem_sel && !i_mem_wr;

  // Control bits follow their byte enables; the interrupt bit is read only.
  assign ctl_wmask = {i_mem_be[1], {8{i_mem_be[0]}}}
                   & lke_pkg::LKE_CTL_WR_MASK;
  assign ctl_wval  = (state_reg.ctl & ~ctl_wmask)
                   | (i_mem_wdata[8:0] & ctl_wmask);

  // Emulation interrupt condition from the status flags, the enable bit and CP.
  assign emul_cond =
      (emulation_enable && state_reg.sts[lke_pkg::LKE_STS_IN_FULL])
    || (!state_reg.sts[lke_pkg::LKE_STS_OUT_FULL]
        && state_reg.ctl[lke_pkg::LKE_CTL_CP]);

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_ctl) begin
      rd_mux[8:0] = state_reg.ctl;
      rd_mux[lke_pkg::LKE_CTL_EI] = emul_cond;
    end else if (sel_in) begin
      rd_mux[7:0] = state_reg.in_data;
    end else if (sel_out) begin
      rd_mux[7:0] = state_reg.out_data;
    end else if (sel_sts) begin
      rd_mux[7:0] = state_reg.sts;
    end
  end

  always_comb begin
    state_next        = state_reg;
    state_next.rvalid = mem_rd;
    state_next.rdata  = mem_rd ? rd_mux : state_reg.rdata;

    // Plain memory writes store values only.
    if (mem_wr && i_mem_be[0]) begin
      if (sel_in) begin
        state_next.in_data = i_mem_wdata[7:0];
      end
      if (sel_out) begin
        state_next.out_data = i_mem_wdata[7:0];
      end
      if (sel_sts) begin
        state_next.sts = i_mem_wdata[7:0];
      end
    end
    if (mem_wr && sel_ctl) begin
      state_next.ctl = ctl_wval;
    end
    state_next.ctl[lke_pkg::LKE_CTL_EI] = 1'b0;

    // Trapped I/O side effects; the decoder only fires while enabled.
    if (trap.rd_data_port) begin
      // A software set of out-full in the same cycle wins.
      if (!(mem_wr && sel_sts && i_mem_be[0]
            && i_mem_wdata[lke_pkg::LKE_STS_OUT_FULL])) begin
        state_next.sts[lke_pkg::LKE_STS_OUT_FULL] = 1'b0;
      end
    end
    if (trap.wr_data_port) begin
      state_next.in_data = trap.wr_byte;
      state_next.sts[lke_pkg::LKE_STS_IN_FULL]  = 1'b1;
      state_next.sts[lke_pkg::LKE_STS_CMD_DATA] = 1'b0;
    end
    if (trap.wr_cmd_port) begin
      state_next.in_data = trap.wr_byte;
      if (!(mem_wr && sel_sts && i_mem_be[0]
            && i_mem_wdata[lke_pkg::LKE_STS_IN_FULL])) begin
        state_next.sts[lke_pkg::LKE_STS_IN_FULL] = 1'b0;
      end
      state_next.sts[lke_pkg::LKE_STS_CMD_DATA] = 1'b1;
    end

    // Emulation interrupt from emul_cond; legacy lines from IRQEN, output-full and the routing bit.
    state_next.irq   = emul_cond;
    state_next.irq1  = state_reg.ctl[lke_pkg::LKE_CTL_IRQEN]
                    && state_reg.sts[lke_pkg::LKE_STS_OUT_FULL]
                    && !state_reg.sts[lke_pkg::LKE_STS_AUX_FULL];
    state_next.irq12 = state_reg.ctl[lke_pkg::LKE_CTL_IRQEN]
                    && state_reg.sts[lke_pkg::LKE_STS_OUT_FULL]
                    && state_reg.sts[lke_pkg::LKE_STS_AUX_FULL];
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg          <= '0;
      state_reg.ctl      <= lke_pkg::LKE_CTL_RST;
      state_reg.in_data  <= lke_pkg::LKE_DATA_RST;
      state_reg.out_data <= lke_pkg::LKE_DATA_RST;
      state_reg.sts      <= lke_pkg::LKE_STS_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_mem_rdata  = state_reg.rdata;
  assign o_mem_rvalid = state_reg.rvalid;
  assign o_emul_irq   = state_reg.irq;
  assign o_irq1       = state_reg.irq1;
  assign o_irq12      = state_reg.irq12;
  assign o_gate_a20   = state_reg.ctl[lke_pkg::LKE_CTL_A20S];

endmodule : lke_top

// File: hw/lke_trap_if.sv
// Connection between the I/O trap decoder and the register core.
`timescale 1ns/100ps
interface lke_trap_if;
  logic       emulation_enable;
  logic [7:0] out_data;
  logic [7:0] status;
  logic       rd_data_port;
  logic       wr_data_port;
  logic       rd_cmd_port;
  logic       wr_cmd_port;
  logic [7:0] wr_byte;

  modport trap (
    input  emulation_enable,
    input  out_data,
    input  status,
    output rd_data_port,
    output wr_data_port,
    output rd_cmd_port,
    output wr_cmd_port,
    output wr_byte
  );

  modport core (
    output emulation_enable,
    output out_data,
    output status,
    input  rd_data_port,
    input  wr_data_port,
    input  rd_cmd_port,
    input  wr_cmd_port,
    input  wr_byte
  );
endinterface : lke_trap_if

// File: verification/lke_kbd_sw.sv
// Legacy keyboard software model issuing port cycles.
`timescale 1ns/100ps
module lke_kbd_sw (
  input  wire logic       i_clk,
  output logic      [7:0] o_io_addr,
  output logic            o_io_rd,
  output logic            o_io_wr,
  output logic      [7:0] o_io_wdata
);
  initial begin
    o_io_addr = 8'h00;
    o_io_rd = 1'b0;
    o_io_wr = 1'b0;
    o_io_wdata = 8'h00;
  end
  // One strobed cycle; afterwards the strobes drop and address and data show inverted values.
  task automatic port_cycle(input logic wr, input logic [7:0] p,
                            input logic [7:0] v);
    o_io_addr = p;
    o_io_wdata = v;
    o_io_rd = !wr;
    o_io_wr = wr;
    @(posedge i_clk);
    #1;
    o_io_rd = 1'b0;
    o_io_wr = 1'b0;
    o_io_addr = ~p;
    o_io_wdata = ~v;
    @(posedge i_clk);
    #1;
  endtask : port_cycle
endmodule : lke_kbd_sw

// File: verification/lke_monitor.sv
// Concurrent checks on the ports of the emulation register block.
`timescale 1ns/100ps
module lke_monitor (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_mem_sel,
  input wire logic        i_mem_wr,
  input wire logic [11:0] i_mem_addr,
  input wire logic [7:0]  i_io_addr,
  input wire logic        i_io_rd,
  input wire logic        i_io_wr,
  input wire logic [31:0] o_mem_rdata,
  input wire logic        o_mem_rvalid,
  input wire logic        o_mem_hit,
  input wire logic        o_io_rvalid,
  input wire logic        o_io_trapped,
  input wire logic        o_emul_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  trap_decode_a: assert property (
    o_io_trapped |-> (i_io_rd || i_io_wr)
      && (i_io_addr == 8'h60 || i_io_addr == 8'h64))
    else $error("bad trap");
  io_answer_a: assert property (
    o_io_trapped && i_io_rd |=> o_io_rvalid)
    else $error("no port answer");
  io_cause_a: assert property (
    o_io_rvalid |-> $past(o_io_trapped) && $past(i_io_rd))
    else $error("stray port answer");
  io_write_quiet_a: assert property (
    o_io_trapped && i_io_wr && !i_io_rd |=> !o_io_rvalid)
    else $error("answer on port write");
  mem_answer_a: assert property (
    i_mem_sel && !i_mem_wr |=> o_mem_rvalid)
    else $error("no memory answer");
  mem_decode_a: assert property (i_mem_sel |-> o_mem_hit ==
    (i_mem_addr inside {12'h100, 12'h104, 12'h108, 12'h10C}))
    else $error("bad decode");
  unmapped_zero_a: assert property (
    i_mem_sel && !i_mem_wr && !o_mem_hit |=> o_mem_rdata == 32'h0)
    else $error("unmapped read not zero");
  irq_quiet_a: assert property ((!i_mem_sel && !o_io_trapped)[*2]
    |=> $stable(o_emul_irq)) else $error("interrupt moved while idle");
endmodule : lke_monitor

// File: verification/tb_top.sv
// Self-checking bench for the legacy keyboard emulation registers.
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  error_cnt++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb_top;
  logic        i_clk, i_sys_rst, i_mem_sel, i_mem_wr, o_mem_rvalid, o_mem_hit;
  logic        i_io_rd, i_io_wr, o_io_rvalid, o_io_trapped, o_emul_irq;
  logic        o_irq1, o_irq12, o_gate_a20;
  logic [3:0]  i_mem_be;
  logic [11:0] i_mem_addr;
  logic [31:0] i_mem_wdata, o_mem_rdata, me, mq[$];
  logic [7:0]  i_io_addr, i_io_wdata, o_io_rdata, st, d, ie, iq[$];
  int          error_cnt, check_count, seed;
  lke_top dut (
    .i_clk        (i_clk),
    .i_sys_rst    (i_sys_rst),
    .i_mem_sel    (i_mem_sel),
    .i_mem_wr     (i_mem_wr),
    .i_mem_addr   (i_mem_addr),
    .i_mem_be     (i_mem_be),
    .i_mem_wdata  (i_mem_wdata),
    .o_mem_rdata  (o_mem_rdata),
    .o_mem_rvalid (o_mem_rvalid),
    .o_mem_hit    (o_mem_hit),
    .i_io_addr    (i_io_addr),
    .i_io_rd      (i_io_rd),
    .i_io_wr      (i_io_wr),
    .i_io_wdata   (i_io_wdata),
    .o_io_rdata   (o_io_rdata),
    .o_io_rvalid  (o_io_rvalid),
    .o_io_trapped (o_io_trapped),
    .o_emul_irq   (o_emul_irq),
    .o_irq1       (o_irq1),
    .o_irq12      (o_irq12),
    .o_gate_a20   (o_gate_a20)
  );
  lke_kbd_sw sw (.i_clk(i_clk), .o_io_addr(i_io_addr), .o_io_rd(i_io_rd),
                 .o_io_wr(i_io_wr), .o_io_wdata(i_io_wdata));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic mem(input logic wr, input logic [11:0] a,
                     input logic [31:0] v);
    i_mem_sel = 1'b1;
    i_mem_wr = wr;
    i_mem_addr = a;
    i_mem_wdata = wr ? v : ~v;
    if (!wr) mq.push_back(v);
    @(posedge i_clk);
    #1;
    i_mem_sel = 1'b0;
    i_mem_addr = ~a;
    @(posedge i_clk);
    #1;
  endtask : mem
  task automatic io(input logic wr, input logic [7:0] p, input logic [7:0] v);
    if (!wr) iq.push_back(v);
    sw.port_cycle(wr, p, v);
  endtask : io
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  always @(posedge i_clk) begin
    #2;
    if (o_mem_rvalid === 1'b1) begin
      me = (mq.size() > 0) ? mq.pop_front() : 32'hDEADBEEF;
      `CHK("mem_rdata", me, o_mem_rdata)
    end
    if (o_io_rvalid === 1'b1) begin
      ie = (iq.size() > 0) ? iq.pop_front() : ~o_io_rdata;
      `CHK("io_rdata", ie, o_io_rdata)
    end
  end
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    i_sys_rst = 1'b1;
    i_mem_sel = 1'b0;
    i_mem_wr = 1'b0;
    i_mem_addr = 12'h000;
    i_mem_be = 4'hF;
    i_mem_wdata = 32'h0;
    seed = 32'hE61014F5;
    error_cnt = 0;
    check_count = 0;
    repeat (4) @(posedge i_clk);
    #1;
    i_sys_rst = 1'b0;
    for (int a = 0; a < 5; a++) begin
      mem(1'b0, 12'h100 + 12'(a * 4), 32'h0);
    end
    $display("reset values done");
    d = 8'($random(seed));
    mem(1'b1, 12'h100, 32'h1);
    mem(1'b0, 12'h100, 32'h1);
    mem(1'b1, 12'h108, {24'h0, d});
    mem(1'b1, 12'h10C, 32'h1);
    io(1'b0, 8'h60, d);
    mem(1'b0, 12'h10C, 32'h0);
    $display("output read done");
    st = 8'h00;
    repeat (6) begin
      d = 8'($random(seed));
      st[1] = d[0];
      st[3] = !d[0];
      io(1'b1, d[0] ? 8'h60 : 8'h64, d);
      mem(1'b0, 12'h104, {24'h0, d});
      io(1'b0, 8'h64, st);
      mem(1'b0, 12'h10C, {24'h0, st});
      `CHK("emul_irq", st[1], o_emul_irq)
    end
    $display("port writes done");
    d = 8'($random(seed));
    mem(1'b1, 12'h104, {24'h0, d});
    mem(1'b0, 12'h104, {24'h0, d});
    mem(1'b0, 12'h10C, {24'h0, st});
    $display("memory access done");
    mem(1'b1, 12'h100, 32'h0);
    io(1'b1, 8'h60, ~d);
    sw.port_cycle(1'b0, 8'h60, 8'h00);
    mem(1'b0, 12'h104, {24'h0, d});
    mem(1'b0, 12'h10C, {24'h0, st});
    `CHK("emul_irq", 1'b0, o_emul_irq)
    $display("disabled done");
    mem(1'b1, 12'h100, 32'h4);
    `CHK("emul_irq", 1'b1, o_emul_irq)
    mem(1'b1, 12'h10C, {24'h0, st | 8'h01});
    `CHK("emul_irq", 1'b0, o_emul_irq)
    `CHK("pending", 0, mq.size() + iq.size())
    $display("interrupt done");
    i_mem_be = 4'h2;
    mem(1'b1, 12'h100, 32'h1FF);
    i_mem_be = 4'hF;
    `CHK("gate_a20", 1'b1, o_gate_a20)
    mem(1'b0, 12'h100, 32'h104);
    mem(1'b1, 12'h100, 32'h8);
    `CHK("irq1", 1'b1, o_irq1)
    `CHK("irq12", 1'b0, o_irq12)
    mem(1'b1, 12'h10C, 32'h21);
    `CHK("irq12", 1'b1, o_irq12)
    `CHK("irq1", 1'b0, o_irq1)
    `CHK("gate_a20", 1'b0, o_gate_a20)
    `CHK("emul_irq", 1'b0, o_emul_irq)
    $display("legacy lines done");
    wrap_up();
  end
endmodule : tb_top
bind lke_top lke_monitor mon (.i_clk, .i_sys_rst, .i_mem_sel, .i_mem_wr,
  .i_mem_addr, .i_io_addr, .i_io_rd, .i_io_wr, .o_mem_rdata, .o_mem_rvalid,
  .o_mem_hit, .o_io_rvalid, .o_io_trapped, .o_emul_irq);
